// file: core/sensor_user_config_registers.sv
// User configuration and status register bank of a humidity sensor.
// Assumes an APB master on pclk, a front end on link_clk and a
// dual-use auxiliary pin resolved by the surrounding pad logic.
//
// Function
// - resolution code from bits seven and zero
// - bit six shows supply low, read-only
// - heater follows bit two of register one
// - registers reset to documented values
// - bit six selects no-hold auxiliary measurement
// - bit five enables thermistor correction
// - bit four selects fast converter mode
// - bit two buffers auxiliary analog inputs
// - bit one selects converter reference
// - bit zero sets auxiliary pin level
// - bit zero initialised from pin
// - heater strength from low nibble
// - reserved bits fixed, writes ignored
// - pin sampled as address low bit
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "sensor_cfg_params.svh"

module sensor_user_config_registers
  import sensor_cfg_pkg::*;
#(
  parameter int   SYNC_STAGES = `SYNC_STAGES,
  parameter int   SETTLE_CYC  = `PIN_SETTLE_CYC
)
(
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog status
  input  wire logic        supply_low_in,
  // Dual-use auxiliary pin
  input  wire logic        aux_drive_pin_i,
  output logic             aux_drive_pin_o,
  output logic             aux_drive_pin_oe,
  output logic             addr_lsb_pin,
  output logic             addr_lsb_valid,
  // Front end domain
  input  wire logic        link_clk,
  output front_cfg_type    link_cfg
);

  // ----------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------
  generate
    if (SYNC_STAGES < 2 || SETTLE_CYC < SYNC_STAGES + 1 ||
        SETTLE_CYC > 255)
    begin : g_bad_param
      $error("sensor_user_config_registers: bad parameters");
    end
  endgenerate

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  logic [7:0]    measure_cfg_r;
  logic [7:0]    aux_cfg_r;
  logic [7:0]    heater_cfg_r;
  logic [7:0]    measure_cfg_nxt;
  logic [7:0]    aux_cfg_nxt;
  logic [7:0]    heater_cfg_nxt;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic          supply_low_s;
  logic          pin_s;
  pin_state_type pin_state_r;
  logic [7:0]    settle_cnt_r;
  logic          pin_done;
  logic          addr_lsb_r;
  logic          addr_valid_r;
  logic          drive_o_r;
  logic          drive_oe_r;
  logic          setup_ph;
  logic          wr_fire;
  logic          hit_measure;
  logic          hit_aux;
  logic          hit_heater;
  logic          hit_any;
  logic          wr_byte;
  logic [7:0]    wbyte;
  logic [7:0]    measure_view;
  logic [7:0]    rd_byte;
  front_cfg_type cfg_now;
  front_cfg_type cfg_hold_r;
  logic          req_tgl_r;
  logic          ack_s;
  logic          busy;
  logic          rstn_link;
  logic          req_link_s;
  logic          req_seen_r;
  logic          ack_tgl_r;
  front_cfg_type link_cfg_r;

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  level_sync #(
    .WIDTH  (2),
    .STAGES (SYNC_STAGES)
  ) u_pin_sync (
    .clk  (pclk),
    .rstn (presetn),
    .d    ({supply_low_in, aux_drive_pin_i}),
    .q    ({supply_low_s, pin_s})
  );

  // ----------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------
  assign setup_ph    = psel && !penable;
  assign hit_measure = (paddr == `OFS_MEASURE_CFG);
  assign hit_aux     = (paddr == `OFS_AUX_CFG);
  assign hit_heater  = (paddr == `OFS_HEATER_CFG);
  assign hit_any     = hit_measure || hit_aux || hit_heater;
  assign wr_fire     = psel && penable && pready_r && pwrite &&
                       !pslverr_r;
  assign wr_byte     = wr_fire && pstrb[0];
  assign wbyte       = pwdata[7:0];

  // ----------------------------------------------------------
  // Read view
  // ----------------------------------------------------------
  // live supply flag
  assign measure_view = {measure_cfg_r[7], supply_low_s,
                         measure_cfg_r[5:0]};
  assign rd_byte = hit_measure ? measure_view :
                   hit_aux     ? aux_cfg_r    :
                   hit_heater  ? heater_cfg_r : 8'h00;

  // ----------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------
  // fixed reserved bits
  assign measure_cfg_nxt = (wr_byte && hit_measure) ?
    ((wbyte & `WR_MASK_MEASURE) |
     (measure_cfg_r & ~`WR_MASK_MEASURE)) : measure_cfg_r;
  assign heater_cfg_nxt = (wr_byte && hit_heater) ?
    ((wbyte & `WR_MASK_HEATER) |
     (heater_cfg_r & ~`WR_MASK_HEATER)) : heater_cfg_r;

  always_comb
  begin
    aux_cfg_nxt = aux_cfg_r;
    if (wr_byte && hit_aux)
      aux_cfg_nxt = (wbyte & `WR_MASK_AUX) |
                    (aux_cfg_r & ~`WR_MASK_AUX);
    if (pin_done)
      aux_cfg_nxt[`BIT_DRIVE] = pin_s;
  end

  // ----------------------------------------------------------
  // Register file
  // ----------------------------------------------------------
  // reset values
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      measure_cfg_r <= `RST_MEASURE_CFG;
      aux_cfg_r     <= `RST_AUX_CFG;
      heater_cfg_r  <= `RST_HEATER_CFG;
    end
    else
    begin
      measure_cfg_r <= measure_cfg_nxt;
      aux_cfg_r     <= aux_cfg_nxt;
      heater_cfg_r  <= heater_cfg_nxt;
    end
  end

  // ----------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph && !hit_any;
      if (setup_ph)
        prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------
  // Power-up pin handling
  // ----------------------------------------------------------
  assign pin_done = (pin_state_r == PIN_SAMPLE) &&
                    (settle_cnt_r == 8'(SETTLE_CYC - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_state_r  <= PIN_SAMPLE;
      settle_cnt_r <= 8'h00;
      addr_lsb_r   <= 1'b0;
      addr_valid_r <= 1'b0;
    end
    else
    begin
      case (pin_state_r)
        PIN_SAMPLE:
        begin
          settle_cnt_r <= settle_cnt_r + 8'h01;
          if (pin_done)
          begin
            addr_lsb_r   <= pin_s;
            addr_valid_r <= 1'b1;
            pin_state_r  <= PIN_DRIVE;
          end
        end
        PIN_DRIVE:
          settle_cnt_r <= settle_cnt_r;
        default:
          pin_state_r <= PIN_SAMPLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_o_r  <= 1'b0;
      drive_oe_r <= 1'b0;
    end
    else
    begin
      drive_o_r  <= aux_cfg_r[`BIT_DRIVE];
      drive_oe_r <= (pin_state_r == PIN_DRIVE);
    end
  end

  assign aux_drive_pin_o  = drive_o_r;
  assign aux_drive_pin_oe = drive_oe_r;
  assign addr_lsb_pin     = addr_lsb_r;
  assign addr_lsb_valid   = addr_valid_r;

  // ----------------------------------------------------------
  // Front end controls
  // ----------------------------------------------------------
  // resolution code
  assign cfg_now.resolution_sel = {measure_cfg_r[`BIT_RES_HI],
                                   measure_cfg_r[`BIT_RES_LO]};
  assign cfg_now.heater_on = measure_cfg_r[`BIT_HEATER_ON];
  assign cfg_now.heater_level = heater_cfg_r[`HEATER_LVL_MSB:0];
  assign cfg_now.aux_no_hold = aux_cfg_r[`BIT_NO_HOLD];
  assign cfg_now.aux_linearize_en = aux_cfg_r[`BIT_LINEARIZE];
  assign cfg_now.adc_fast_sel = aux_cfg_r[`BIT_FAST];
  assign cfg_now.aux_input_buffer_en = aux_cfg_r[`BIT_IN_BUF];
  assign cfg_now.adc_ref_sel = aux_cfg_r[`BIT_REF_SEL];

  // ----------------------------------------------------------
  // Crossing to the front end: toggle handshake
  // ----------------------------------------------------------
  assign busy = (req_tgl_r != ack_s);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_hold_r <= '0;
      req_tgl_r  <= 1'b0;
    end
    else if (!busy && (cfg_now != cfg_hold_r))
    begin
      cfg_hold_r <= cfg_now;
      req_tgl_r  <= !req_tgl_r;
    end
  end

  level_sync #(
    .WIDTH  (1),
    .STAGES (SYNC_STAGES)
  ) u_ack_sync (
    .clk  (pclk),
    .rstn (presetn),
    .d    (ack_tgl_r),
    .q    (ack_s)
  );

  // ----------------------------------------------------------
  // Front end domain
  // ----------------------------------------------------------
  level_sync #(
    .WIDTH  (1),
    .STAGES (SYNC_STAGES)
  ) u_link_rst (
    .clk  (link_clk),
    .rstn (presetn),
    .d    (1'b1),
    .q    (rstn_link)
  );

  level_sync #(
    .WIDTH  (1),
    .STAGES (SYNC_STAGES)
  ) u_req_sync (
    .clk  (link_clk),
    .rstn (rstn_link),
    .d    (req_tgl_r),
    .q    (req_link_s)
  );

  always_ff @(posedge link_clk or negedge rstn_link)
  begin
    if (!rstn_link)
    begin
      req_seen_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
      link_cfg_r <= '0;
    end
    else
    begin
      req_seen_r <= req_link_s;
      ack_tgl_r  <= req_link_s;
      if (req_link_s != req_seen_r)
        link_cfg_r <= cfg_hold_r;
    end
  end

  assign link_cfg = link_cfg_r;

endmodule // sensor_user_config_registers

// file: core/sensor_cfg_params.svh
// Constants of the sensor user configuration register bank.
// Assumes inclusion by bare name from package and modules.
`ifndef SENSOR_CFG_PARAMS_SVH
`define SENSOR_CFG_PARAMS_SVH

// ----------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------
`define OFS_MEASURE_CFG   12'h000
`define OFS_AUX_CFG       12'h004
`define OFS_HEATER_CFG    12'h008

// ----------------------------------------------------------
// Reset values
// ----------------------------------------------------------
`define RST_MEASURE_CFG   8'h3A
`define RST_AUX_CFG       8'h08
`define RST_HEATER_CFG    8'h00

// ----------------------------------------------------------
// Writable bit masks; other bits are fixed
// ----------------------------------------------------------
`define WR_MASK_MEASURE   8'h85
`define WR_MASK_AUX       8'h77
`define WR_MASK_HEATER    8'h0F

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define BIT_RES_HI        7
`define BIT_RES_LO        0
`define BIT_SUPPLY_LOW    6
`define BIT_HEATER_ON     2
`define BIT_NO_HOLD       6
`define BIT_LINEARIZE     5
`define BIT_FAST          4
`define BIT_IN_BUF        2
`define BIT_REF_SEL       1
`define BIT_DRIVE         0
`define HEATER_LVL_MSB    3

// ----------------------------------------------------------
// Timing counts
// ----------------------------------------------------------
`define SYNC_STAGES       2
`define PIN_SETTLE_CYC    4

`endif

// file: core/sensor_cfg_pkg.sv
// Types of the sensor user configuration register bank.
// Assumes the params header sits in the include path.
package sensor_cfg_pkg;

  // Controls handed to the measurement front end
  typedef struct packed {
    logic [1:0] resolution_sel;
    logic       heater_on;
    logic [3:0] heater_level;
    logic       aux_no_hold;
    logic       aux_linearize_en;
    logic       adc_fast_sel;
    logic       aux_input_buffer_en;
    logic       adc_ref_sel;
  } front_cfg_type;

  // Power-up handling of the dual-use pin
  typedef enum logic {
    PIN_SAMPLE,
    PIN_DRIVE
  } pin_state_type;

endpackage

// file: core/level_sync.sv
// Multi-stage synchroniser for levels into one clock domain.
// Assumes the input is a level that is stable for several cycles.
`timescale 1ns/1ps
module level_sync
#(
  parameter int   WIDTH  = 1,
  parameter int   STAGES = 2
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage_r [STAGES];

  generate
    if (STAGES < 2)
    begin : g_bad
      $error("level_sync needs at least two stages");
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < STAGES; i++)
        stage_r[i] <= '0;
    end
    else
    begin
      stage_r[0] <= d;
      for (int i = 1; i < STAGES; i++)
        stage_r[i] <= stage_r[i-1];
    end
  end

  assign q = stage_r[STAGES-1];

endmodule // level_sync

// file: testbench/sensor_cfg_properties.sv
// Concurrent checks on the ports of the user register bank.
// Assumes a bind onto the bank top module, pclk domain only.
`timescale 1ns/1ps
module sensor_cfg_checker
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Auxiliary pin
  input wire logic        aux_drive_pin_o,
  input wire logic        aux_drive_pin_oe,
  input wire logic        addr_lsb_pin,
  input wire logic        addr_lsb_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = psel && penable && pready && !pwrite && !pslverr;

  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  property p_answer;
    psel && !penable |=> pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer after setup");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  property p_upper;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read bits not zero");
  property p_rsv1;
    rd && paddr == 12'h000 |-> prdata[5:3] == 3'h7 && prdata[1];
  endproperty
  a_rsv1: assert property (p_rsv1)
    else $error("register one fixed bits wrong");
  property p_rsv2;
    rd && paddr == 12'h004 |-> !prdata[7] && prdata[3];
  endproperty
  a_rsv2: assert property (p_rsv2)
    else $error("register two fixed bits wrong");
  property p_rsv3;
    rd && paddr == 12'h008 |-> prdata[7:4] == 4'h0;
  endproperty
  a_rsv3: assert property (p_rsv3)
    else $error("register three fixed bits wrong");
  property p_pinrd;
    rd && paddr == 12'h004 |-> prdata[0] == aux_drive_pin_o;
  endproperty
  a_pinrd: assert property (p_pinrd)
    else $error("pin level differs from bit zero");
  property p_oe;
    $rose(addr_lsb_valid) |=> $rose(aux_drive_pin_oe);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin not driven after strap");
  property p_strap;
    $rose(aux_drive_pin_oe) |-> aux_drive_pin_o == addr_lsb_pin;
  endproperty
  a_strap: assert property (p_strap)
    else $error("drive level not strap level");
  property p_hold;
    addr_lsb_valid |=> addr_lsb_valid && $stable(addr_lsb_pin);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address bit changed");
endmodule // sensor_cfg_checker

// file: testbench/aux_pad_model.sv
// Board side of the dual-use auxiliary pin.
// Assumes a static tie level behind a weak resistor.
`timescale 1ns/1ps
module aux_pad_model
(
  // Board tie level
  input  wire logic strap_level,
  // Pin from the bank
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      pin_i
);
  assign pin_i = pin_oe ? pin_o : strap_level;
endmodule // aux_pad_model

// file: testbench/tb_top.sv
// Self-checking bench of the user register bank.
// Assumes the bank, its package and the pad model are compiled first.
`timescale 1ns/1ps
module tb_top
  import sensor_cfg_pkg::*;
;
  logic          pclk, link_clk, presetn, psel, penable, pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd_data;
  logic [3:0]    pstrb;
  logic          pready, pslverr, rd_err, supply_low_in, strap;
  logic          aux_drive_pin_i, aux_drive_pin_o, aux_drive_pin_oe;
  logic          addr_lsb_pin, addr_lsb_valid;
  logic [7:0]    mod_meas, mod_aux, mod_heat;
  front_cfg_type link_cfg;
  int            errors, total_checks;

  sensor_user_config_registers #(.SYNC_STAGES(2), .SETTLE_CYC(4)) u_dut
  (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
   .prdata, .pready, .pslverr, .supply_low_in, .aux_drive_pin_i,
   .aux_drive_pin_o, .aux_drive_pin_oe, .addr_lsb_pin, .addr_lsb_valid,
   .link_clk, .link_cfg);

  aux_pad_model u_pad
  (.strap_level(strap), .pin_o(aux_drive_pin_o),
   .pin_oe(aux_drive_pin_oe), .pin_i(aux_drive_pin_i));

  // ----------------------------------------------------------
  // Clocks and watchdog
  // ----------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial
  begin
    link_clk = 1'b0;
    #1.7;
    forever #6 link_clk = ~link_clk;
  end
  initial
  begin
    #100000;
    errors++;
    end_of_test;
  end

  // ----------------------------------------------------------
  // Tasks and model
  // ----------------------------------------------------------
  task automatic end_of_test;
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [11:0] ad, input logic w,
                     input logic [7:0] d, input logic s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= ad;
    pwrite  <= w;
    pwdata  <= {24'h0, d};
    pstrb   <= {3'h0, s};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] exp_rd(input logic [11:0] ad);
    case (ad)
      12'h000: exp_rd = {24'h0, mod_meas[7], supply_low_in, mod_meas[5:0]};
      12'h004: exp_rd = {24'h0, mod_aux};
      12'h008: exp_rd = {24'h0, mod_heat};
      default: exp_rd = 32'h0;
    endcase
  endfunction

  task automatic rd_chk(input logic [11:0] ad);
    apb(ad, 1'b0, 8'h00, 1'b0);
    chk(rd_data, exp_rd(ad));
    chk(32'(rd_err), 32'(ad > 12'h008));
  endtask

  task automatic link_chk;
    front_cfg_type e;
    int n;
    e = {mod_meas[7], mod_meas[0], mod_meas[2], mod_heat[3:0],
         mod_aux[6:4], mod_aux[2:1]};
    n = 0;
    while (link_cfg !== e && n < 60)
    begin
      @(posedge pclk);
      n++;
    end
    chk(32'(link_cfg), 32'(e));
  endtask

  task automatic put(input logic [11:0] ad, input logic [7:0] d,
                     input logic s);
    apb(ad, 1'b1, d, s);
    chk(32'(rd_err), 32'(ad > 12'h008));
    if (s)
      case (ad)
        12'h000: mod_meas = (mod_meas & 8'h7A) | (d & 8'h85);
        12'h004: mod_aux  = (mod_aux & 8'h88) | (d & 8'h77);
        12'h008: mod_heat = d & 8'h0F;
        default: ;
      endcase
    for (int i = 0; i < 3; i++)
      rd_chk(12'(i * 4));
    chk(32'(aux_drive_pin_o), 32'(mod_aux[0]));
    link_chk;
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial
  begin
    errors = 0;
    total_checks = 0;
    void'($urandom(25587));
    strap = 1'($urandom);
    {presetn, psel, penable, pwrite, supply_low_in} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mod_meas = 8'h3A;
    mod_aux = {7'h04, strap};
    mod_heat = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    for (int i = 0; i < 3; i++)
      rd_chk(12'(i * 4));
    chk(32'(addr_lsb_pin), 32'(strap));
    link_chk;
    for (int c = 0; c < 4; c++)
      put(12'h000, {c[1], 6'($urandom), c[0]}, 1'b1);
    for (int k = 0; k < 8; k++)
      put(12'h004, 8'($urandom), 1'b1);
    rd_chk(12'h004);
    put(12'h004, rd_data[7:0] & 8'h9F, 1'b1);
    put(12'h008, 8'hFF, 1'b1);
    put(12'h008, 8'h00, 1'b1);
    put(12'h008, 8'h5A, 1'b0);
    put(12'h00C, 8'hFF, 1'b1);
    supply_low_in <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk(12'h000);
    put(12'h000, 8'hFF, 1'b1);
    end_of_test;
  end
endmodule // tb_top

bind sensor_user_config_registers sensor_cfg_checker u_chk
(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
 .pslverr, .aux_drive_pin_o, .aux_drive_pin_oe, .addr_lsb_pin,
 .addr_lsb_valid);
